/* File: design/cff_pkg.sv */
// cff_pkg: constants and carrier types for the channel fault flag logic
// assumes a 40 MHz device clock and four channels a..d
package cff_pkg;
   localparam int          NUM_CHAN       = 4;
   localparam int          CLK_HZ         = 40000000;
   // fixed debounce for output functions, in microseconds
   localparam int          OUT_DEB_US     = 2000;
   localparam int          OUT_DEB_CYC    = (CLK_HZ / 1000000) * OUT_DEB_US;
   // user debounce step: one code unit is this many microseconds
   localparam int          IN_DEB_STEP_US = 10;
   localparam int          IN_DEB_STEP    = (CLK_HZ / 1000000) * IN_DEB_STEP_US;
   localparam int          CNT_W          = 24;
   localparam int          DEB_CODE_W     = 5;
   // bit positions of the channel fault flags in the status word
   localparam int          FLAG_POS_A     = 0;
   localparam logic [15:0] STATUS_RST     = 16'h0000;
   localparam logic [15:0] MASK_RST       = 16'h0000;

   // channel functions, as selected per channel
   typedef enum logic [2:0]
   {
      CFF_HIGH_Z   = 3'h0,
      CFF_VOUT     = 3'h1,
      CFF_IOUT     = 3'h2,
      CFF_VIN      = 3'h3,
      CFF_IIN_EXT  = 3'h4,
      CFF_IIN_LOOP = 3'h5
   } cff_func_e;

   // per-channel configuration seen by the fault logic
   typedef struct packed
   {
      cff_func_e              func;
      logic                   comp_en;
      logic                   comp_invert;
      logic                   trip_half_rail;
      logic [DEB_CODE_W-1:0]  deb_code;
   } cff_chan_cfg_s;

   // per-channel raw fault indications from the analog side
   typedef struct packed
   {
      logic short_circuit;
      logic open_circuit;
      logic comp_out;
   } cff_chan_sense_s;

   // debounce state kept per channel
   typedef struct packed
   {
      logic [CNT_W-1:0] cnt;
      logic             live;
   } cff_deb_s;
endpackage

/* File: design/cff_fault_flags.sv */
// cff_fault_flags: per-channel fault debounce, sticky and live flags, alert
// assumes synchronous sense inputs and a one-cycle status write strobe
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - four channel fault flags, channel a at bit 0 to d at bit 3
// - meaning of each flag follows that channel's selected function
// - voltage output short sets flag after 2 ms persistence
// - current output open circuit sets flag after 2 ms persistence
// - loop-powered input flags ground short via comparator at half rail
// - both current-input functions use user debounce time from input config
// - externally powered input flags overcurrent via comparator at half rail
// - live register shows unlatched fault condition per channel
// - alert asserts for any status flag whose mask bit is clear
module cff_fault_flags
(
   input  wire logic                      ref_clk_in,
   input  wire logic                      resetn_in,
   input  wire cff_pkg::cff_chan_cfg_s    chan_cfg_in   [cff_pkg::NUM_CHAN],
   input  wire cff_pkg::cff_chan_sense_s  chan_sense_in [cff_pkg::NUM_CHAN],
   input  wire logic                      status_wr_in,
   input  wire logic [15:0]               status_wdata_in,
   input  wire logic [15:0]               alert_mask_in,
   output logic [15:0]                    alert_status_flags_out,
   output logic [cff_pkg::NUM_CHAN-1:0]   fault_live_out,
   output logic                           alert_n_out
);

   // all module state in one packed struct
   typedef struct packed
   {
      cff_pkg::cff_deb_s [cff_pkg::NUM_CHAN-1:0] deb;
      logic [cff_pkg::NUM_CHAN-1:0]              flags;
      logic                                      alert_n;
   } cff_state_s;

   cff_state_s state_reg;
   cff_state_s state_next;

   // one element per channel, so each generate branch owns its own variable
   logic                           cond  [cff_pkg::NUM_CHAN];
   logic [cff_pkg::CNT_W-1:0]      limit [cff_pkg::NUM_CHAN];

   // raw condition and debounce limit per channel
   genvar g;
   generate
      for (g = 0; g < cff_pkg::NUM_CHAN; g = g + 1)
      begin : g_chan
         logic comp_ok;
         assign comp_ok = chan_sense_in[g].comp_out
                        & chan_cfg_in[g].comp_en
                        & chan_cfg_in[g].trip_half_rail;
         always_comb
         begin
            cond[g]  = 1'b0;
            limit[g] = cff_pkg::CNT_W'(cff_pkg::OUT_DEB_CYC);
            case (chan_cfg_in[g].func)
               cff_pkg::CFF_VOUT:
                  cond[g] = chan_sense_in[g].short_circuit;
               cff_pkg::CFF_IOUT:
                  cond[g] = chan_sense_in[g].open_circuit;
               cff_pkg::CFF_IIN_LOOP:
               begin
                  // inverted comparator output marks a ground short
                  cond[g]  = comp_ok & chan_cfg_in[g].comp_invert;
                  limit[g] = cff_pkg::CNT_W'(chan_cfg_in[g].deb_code
                           * cff_pkg::IN_DEB_STEP);
               end
               cff_pkg::CFF_IIN_EXT:
               begin
                  cond[g]  = comp_ok;
                  limit[g] = cff_pkg::CNT_W'(chan_cfg_in[g].deb_code
                           * cff_pkg::IN_DEB_STEP);
               end
               default:
                  cond[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   // next state: debounce counters, sticky flags, alert
   always_comb
   begin
      logic [cff_pkg::NUM_CHAN-1:0] clr;
      logic [cff_pkg::NUM_CHAN-1:0] setf;
      clr  = '0;
      setf = '0;
      state_next = state_reg;
      clr = status_wr_in ? status_wdata_in[cff_pkg::NUM_CHAN-1:0] : '0;
      for (int i = 0; i < cff_pkg::NUM_CHAN; i++)
      begin
         // counter parks one short of the limit while the fault stands,
         // so the flag is set again every cycle the fault persists
         if (!cond[i])
         begin
            state_next.deb[i].cnt  = '0;
            state_next.deb[i].live = 1'b0;
         end
         else if (state_reg.deb[i].cnt + 1'b1 >= limit[i])
         begin
            state_next.deb[i].live = 1'b1;
            setf[i] = 1'b1;
         end
         else
         begin
            state_next.deb[i].cnt = state_reg.deb[i].cnt + 1'b1;
         end
      end
      // set wins over a same-cycle write-one clear
      state_next.flags = (state_reg.flags & ~clr) | setf;
      state_next.alert_n = ~|(state_next.flags
                         & ~alert_mask_in[cff_pkg::NUM_CHAN-1:0]);
   end

   // state register
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state_reg.deb     <= '0;
         state_reg.flags   <= cff_pkg::STATUS_RST[cff_pkg::NUM_CHAN-1:0];
         state_reg.alert_n <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign alert_status_flags_out = {12'h000, state_reg.flags};
   always_comb
   begin
      for (int i = 0; i < cff_pkg::NUM_CHAN; i++)
      begin
         fault_live_out[i] = state_reg.deb[i].live;
      end
   end
   assign alert_n_out = state_reg.alert_n;

   // flag storage: sticky until a one is written, set beats clear
   a_flag_sticky: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (state_reg.flags[0] && !(status_wr_in && status_wdata_in[0]))
      |=> state_reg.flags[0])
      else $error("fault flag a dropped without clear");
   a_flag_clear: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (status_wr_in && status_wdata_in[1] && !cond[1])
      |=> !state_reg.flags[1])
      else $error("fault flag b not cleared");

   // clear attempt on channel a while its fault still holds
   sequence s_clear_a_live;
      status_wr_in && status_wdata_in[0]
      && fault_live_out[0] && cond[0];
   endsequence

   // zero write while channel c is flagged
   sequence s_zero_write_c;
      status_wr_in && !status_wdata_in[2] && alert_status_flags_out[2];
   endsequence

   a_set_wins: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      s_clear_a_live |=> alert_status_flags_out[0])
      else $error("clear beat a standing fault");
   a_zero_write: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      s_zero_write_c |=> alert_status_flags_out[2])
      else $error("zero write cleared a flag");
   a_upper_zero: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      alert_status_flags_out[15:4] == 12'h000)
      else $error("flag outside channel bits");

   // live copy follows the debounced condition
   a_live_sets: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      $rose(fault_live_out[2]) |-> alert_status_flags_out[2])
      else $error("live without sticky flag");
   a_live_drops: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      !cond[3] |=> !fault_live_out[3])
      else $error("live flag held without condition");

   // alert pin: low for every unmasked flag, and only for one
   a_alert_mask: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (alert_status_flags_out[0] && !alert_mask_in[0]
       && !(status_wr_in && status_wdata_in[0])
       && $stable(alert_mask_in[0])) |=> !alert_n_out)
      else $error("alert not raised");
   a_alert_source: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      !alert_n_out |-> |(alert_status_flags_out[3:0]
                        & ~$past(alert_mask_in[3:0])))
      else $error("alert without unmasked flag");

   // condition sources per selected function
   a_vout_debounce: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (chan_cfg_in[0].func == cff_pkg::CFF_VOUT && $rose(cond[0]))
      |=> !fault_live_out[0])
      else $error("short flagged before debounce");
   a_iout_source: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (chan_cfg_in[1].func == cff_pkg::CFF_IOUT) |->
      cond[1] == chan_sense_in[1].open_circuit)
      else $error("open circuit not selected");
   a_loop_invert: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (chan_cfg_in[2].func == cff_pkg::CFF_IIN_LOOP
       && !chan_cfg_in[2].comp_invert) |-> !cond[2])
      else $error("loop short without inversion");
   a_ext_comp: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      (chan_cfg_in[3].func == cff_pkg::CFF_IIN_EXT && !chan_cfg_in[3].comp_en)
      |-> !cond[3])
      else $error("overcurrent without comparator");
endmodule
`default_nettype wire

/* File: tb/cff_field_model.sv */
// cff_field_model: field wiring at the four channel terminals
// assumes the bench picks a fault pattern per channel: short, open, comp
`timescale 1ns/100ps
`default_nettype none
module cff_field_model
(
   input  wire logic                    ref_clk_in,
   input  wire logic [2:0]              fault_in  [cff_pkg::NUM_CHAN],
   output var cff_pkg::cff_chan_sense_s sense_out [cff_pkg::NUM_CHAN]
);
   // terminal conditions settle one clock after the wiring changes
   always_ff @(posedge ref_clk_in)
   begin
      for (int i = 0; i < cff_pkg::NUM_CHAN; i++)
         sense_out[i] <= cff_pkg::cff_chan_sense_s'(fault_in[i]);
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// tb: self-checking bench for the channel fault flag logic
// assumes the field model drives the sense inputs of all four channels
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int            DLY = 2;
   localparam int            DEB = cff_pkg::OUT_DEB_CYC;
   logic                     ref_clk_in;
   logic                     resetn_in;
   logic                     status_wr;
   logic [15:0]              wdata;
   logic [15:0]              mask;
   logic [15:0]              flags;
   logic [3:0]               live;
   logic                     alert_n;
   logic [2:0]               fault [cff_pkg::NUM_CHAN];
   cff_pkg::cff_chan_cfg_s   cfg   [cff_pkg::NUM_CHAN];
   cff_pkg::cff_chan_sense_s sense [cff_pkg::NUM_CHAN];
   int                       n_errors = 0;
   int                       checks = 0;
   // free-running device clock
   initial
   begin
      ref_clk_in = 1'h0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   cff_field_model i_field (.ref_clk_in(ref_clk_in), .fault_in(fault),
      .sense_out(sense));
   cff_fault_flags i_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .chan_cfg_in(cfg), .chan_sense_in(sense), .status_wr_in(status_wr),
      .status_wdata_in(wdata), .alert_mask_in(mask),
      .alert_status_flags_out(flags), .fault_live_out(live),
      .alert_n_out(alert_n));
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #DLY;
   endtask
   // one-cycle status write, then one idle edge before the next request
   task automatic wr(input logic [15:0] d);
      status_wr = 1'h1;
      wdata = d;
      cyc(1);
      status_wr = 1'h0;
      cyc(1);
   endtask
   task automatic end_sim;
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // input functions, d masked, c needs inversion first
   task automatic t_inputs;
      fault[2] = 3'h1;
      fault[3] = 3'h1;
      cyc(370);
      chk(flags, 16'h0000);
      cyc(60);
      chk(flags, 16'h0008);
      chk({15'h0000, alert_n}, 16'h0001);
      cyc(500);
      chk(flags, 16'h0008);
      cfg[2].comp_invert = 1'h1;
      cyc(770);
      chk(flags, 16'h0008);
      cyc(60);
      chk(flags, 16'h000C);
      chk({11'h000, live, alert_n}, 16'h0018);
   endtask
   // write zero, then clear one bit at a time
   task automatic t_clear;
      wr(16'h0000);
      chk(flags, 16'h000C);
      fault[2] = 3'h0;
      fault[3] = 3'h0;
      cyc(3);
      chk({12'h000, live}, 16'h0000);
      wr(16'h0004);
      chk({flags[14:0], alert_n}, 16'h0011);
      wr(16'h0008);
      chk(flags, 16'h0000);
   endtask
   // output functions; all fault kinds on voltage input, comparator off ignored
   task automatic t_outputs;
      cfg[2].func = cff_pkg::CFF_VIN;
      cfg[3].comp_en = 1'h0;
      fault[0] = 3'h4;
      fault[1] = 3'h2;
      fault[2] = 3'h7;
      fault[3] = 3'h1;
      cyc(DEB - 40);
      chk(flags, 16'h0000);
      cyc(80);
      chk(flags, 16'h0003);
      chk({11'h000, live, alert_n}, 16'h0006);
      wr(16'h0001);
      chk(flags, 16'h0003);
      fault[0] = 3'h0;
      fault[1] = 3'h0;
      cyc(3);
      wr(16'h0003);
      chk({flags[14:0], alert_n}, 16'h0001);
   endtask
   // configure, reset, run scenarios
   initial
   begin
      resetn_in = 1'h0;
      status_wr = 1'h0;
      wdata = 16'h0000;
      mask = 16'h0008;
      for (int i = 0; i < cff_pkg::NUM_CHAN; i++)
      begin
         cfg[i] = '0;
         cfg[i].comp_en = 1'h1;
         cfg[i].trip_half_rail = 1'h1;
         fault[i] = 3'h0;
      end
      cfg[0].func = cff_pkg::CFF_VOUT;
      cfg[1].func = cff_pkg::CFF_IOUT;
      cfg[2].func = cff_pkg::CFF_IIN_LOOP;
      cfg[2].deb_code = 5'h02;
      cfg[3].func = cff_pkg::CFF_IIN_EXT;
      cfg[3].deb_code = 5'h01;
      cyc(4);
      resetn_in = 1'h1;
      chk({11'h000, live, alert_n}, 16'h0001);
      t_inputs();
      t_clear();
      t_outputs();
      end_sim();
   end
   // hang guard
   initial
   begin
      #3000000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
